// ### logic/asc_pkg.sv
// Purpose: shared constants and types of the antenna service / CAN node block
// Assumes: 250 MHz clock, 16-bit register port
// Notes:   offsets are word indexes on the plain register port
package asc_pkg;
    // register indexes
    localparam logic [3:0] ASC_A_CMD  = 4'h0;
    localparam logic [3:0] ASC_A_FILT = 4'h1;
    localparam logic [3:0] ASC_A_BAUD = 4'h2;
    localparam logic [3:0] ASC_A_EVT  = 4'h3;
    localparam logic [3:0] ASC_A_INH  = 4'h4;
    localparam logic [3:0] ASC_A_HB   = 4'h5;
    localparam logic [3:0] ASC_A_OPT  = 4'h6;
    localparam logic [3:0] ASC_A_PROG = 4'h7;
    localparam logic [3:0] ASC_A_STAT = 4'h8;
    localparam logic [3:0] ASC_A_INT  = 4'h9;
    localparam logic [3:0] ASC_A_CODE = 4'ha;
    // command bits
    localparam int ASC_CB_APPLY = 0;
    localparam int ASC_CB_SAVE  = 1;
    localparam int ASC_CB_DEF   = 2;
    localparam int ASC_CB_WRTAG = 3;
    // option bits
    localparam int ASC_OB_AUTO  = 0;
    localparam int ASC_OB_SWAP  = 1;
    localparam int ASC_OB_SDOD  = 2;
    localparam int ASC_OB_FAST  = 3;
    // internal status bits
    localparam int ASC_IS_BAUD  = 0;
    localparam int ASC_IS_RANGE = 1;
    // factory defaults
    localparam logic [7:0]  ASC_DEF_FILT = 8'h00;
    localparam logic [2:0]  ASC_DEF_BAUD = 3'h2;
    localparam logic [15:0] ASC_DEF_EVT  = 16'h0064;
    localparam logic [15:0] ASC_DEF_INH  = 16'h0003;
    localparam logic [15:0] ASC_DEF_HB   = 16'h03e8;
    localparam logic [3:0]  ASC_DEF_OPT  = 4'h1;
    // limits
    localparam logic [2:0]  ASC_BAUD_MAX = 3'h6;
    localparam logic [15:0] ASC_EVT_MIN  = 16'h000a;
    localparam logic [15:0] ASC_INH_MIN  = 16'h0003;
    localparam logic [15:0] ASC_HB_MIN   = 16'h000a;
    // timing
    localparam int ASC_CLK_PS = 4000;
    localparam int ASC_MS_PS  = 1000000000;
    localparam int ASC_MS_CYC = ASC_MS_PS / ASC_CLK_PS;
    // node states
    typedef enum logic [1:0] {
        ASC_ST_STOP = 2'b00,
        ASC_ST_PRE  = 2'b01,
        ASC_ST_OP   = 2'b10
    } asc_node_t;
endpackage

// ### logic/asc_ms_tick.sv
// Purpose: one-cycle enable pulse every millisecond
// Assumes: MS_CYC at least 2
// Notes:   free running, no phase alignment to events
`timescale 1ns/1ns
module asc_ms_tick #(
    parameter int MS_CYC = 250000
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_resetn,
    // tick out
    output logic      o_tick
);
    localparam int W = $clog2(MS_CYC);
    localparam logic [W-1:0] LAST = W'(MS_CYC - 1);
    logic [W-1:0] cnt_reg;

    // divider counter and tick
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= '0;
            o_tick  <= 1'b0;
        end else begin
            o_tick  <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule

// ### logic/asc_ms_count.sv
// Purpose: saturating millisecond counter with synchronous clear
// Assumes: i_tick is a one-cycle pulse
// Notes:   clear wins over tick
`timescale 1ns/1ns
module asc_ms_count (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    // control
    input  wire logic        i_tick,
    input  wire logic        i_clear,
    // count
    output logic [15:0]      o_count
);
    // count ms, hold at top
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_count <= 16'h0000;
        end else if (i_clear) begin
            o_count <= 16'h0000;
        end else if (i_tick && o_count != 16'hffff) begin
            o_count <= o_count + 16'h0001;
        end
    end
endmodule

// ### logic/asc_top.sv
// Purpose: service configuration and CAN node timing of a tag reader
// Assumes: inputs synchronous to i_clock; CAN framing done outside
// Notes:   edits go to shadow values; apply or save makes them active, but the filter gap and fast mode act at once
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module asc_top
    import asc_pkg::*;
#(
    parameter int MS_CYC = ASC_MS_CYC
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic [15:0]      o_rdata,
    // reader side
    input  wire logic        i_data_present,
    input  wire logic        i_tag_valid,
    input  wire logic [15:0] i_tag_code,
    // CAN controller and master
    input  wire logic        i_bus_off,
    input  wire logic        i_bus_lost,
    input  wire logic        i_nmt_start,
    input  wire logic        i_nmt_preop,
    input  wire logic        i_nmt_stop,
    input  wire logic        i_sdo_prog_req,
    input  wire logic        i_rpdo_prog_req,
    input  wire logic [15:0] i_req_code,
    // events out
    output logic             o_position_pulse,
    output logic             o_tpdo_send,
    output logic [15:0]      o_tpdo_code,
    output logic             o_heartbeat_send,
    output logic             o_node_reset,
    output logic             o_nvm_save,
    output logic             o_nvm_default,
    output logic             o_prog_start,
    output logic [15:0]      o_prog_code,
    // status out
    output logic [1:0]       o_node_state,
    output logic             o_can_online,
    output logic [2:0]       o_baud_sel,
    output logic             o_fast_mode
);
    // shadow (edited) settings
    logic [7:0]  filt_reg;
    logic [2:0]  baud_s_reg;
    logic [15:0] evt_s_reg;
    logic [15:0] inh_s_reg;
    logic [15:0] hb_s_reg;
    logic [3:0]  opt_s_reg;
    logic [15:0] prog_reg;
    // active settings
    logic [15:0] evt_reg;
    logic [15:0] inh_reg;
    logic [15:0] hb_reg;
    logic [3:0]  opt_reg;
    // state
    logic [1:0]  int_reg;
    logic        nrst_reg;
    asc_node_t   state_reg;
    logic        was_op_reg;
    logic        pend_reg;
    logic        armed_reg;
    logic [15:0] last_code_reg;
    // counters
    logic        tick;
    logic [15:0] since_cnt;
    logic [15:0] hb_cnt;
    logic [15:0] posi_cnt;

    // command decode
    logic cmd_wr;
    logic apply;
    logic save;
    logic wr_def;
    logic sw_prog;
    assign cmd_wr  = i_write && (i_addr == ASC_A_CMD);
    assign apply   = cmd_wr && i_wdata[ASC_CB_APPLY];
    assign save    = cmd_wr && i_wdata[ASC_CB_SAVE];
    assign wr_def  = cmd_wr && i_wdata[ASC_CB_DEF];
    assign sw_prog = cmd_wr && i_wdata[ASC_CB_WRTAG];

    // range checks of written values
    logic baud_ok;
    logic evt_ok;
    logic inh_ok_w;
    logic hb_ok;
    assign baud_ok  = i_wdata[2:0] <= ASC_BAUD_MAX;
    assign evt_ok   = i_wdata == 16'h0000 || i_wdata >= ASC_EVT_MIN;
    assign inh_ok_w = i_wdata == 16'h0000 || i_wdata >= ASC_INH_MIN;
    assign hb_ok    = i_wdata == 16'h0000 || i_wdata >= ASC_HB_MIN;

    // millisecond time base
    asc_ms_tick #(.MS_CYC(MS_CYC)) u_tick (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .o_tick   (tick)
    );

    // process data, heartbeat and filter fire conditions
    logic both_zero;
    logic inh_done;
    logic evt_due;
    logic tpdo_fire;
    logic hb_fire;
    logic posi_fire;
    logic new_code;
    logic prog_fire;
    assign both_zero = evt_reg == 16'h0000 && inh_reg == 16'h0000;
    assign inh_done  = since_cnt >= inh_reg;
    assign evt_due   = evt_reg != 16'h0000 && since_cnt >= evt_reg;
    assign tpdo_fire = pend_reg && state_reg == ASC_ST_OP && !both_zero && inh_done && !o_tpdo_send;
    assign hb_fire   = hb_reg != 16'h0000 && hb_cnt >= hb_reg && !o_heartbeat_send;
    assign posi_fire = armed_reg && !i_data_present && posi_cnt >= {8'h00, filt_reg};
    assign new_code  = i_tag_valid && i_tag_code != last_code_reg;
    assign prog_fire = sw_prog || i_rpdo_prog_req || (i_sdo_prog_req && !opt_reg[ASC_OB_SDOD]);

    // time since last process data
    asc_ms_count u_since (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_tick   (tick),
        .i_clear  (tpdo_fire || nrst_reg),
        .o_count  (since_cnt)
    );

    // time since last heartbeat
    asc_ms_count u_hb (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_tick   (tick),
        .i_clear  (hb_fire || nrst_reg),
        .o_count  (hb_cnt)
    );

    // time the decoded-data indication has been absent
    asc_ms_count u_posi (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_tick   (tick),
        .i_clear  (i_data_present),
        .o_count  (posi_cnt)
    );

    // shadow settings edited by software
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            filt_reg   <= ASC_DEF_FILT;
            baud_s_reg <= ASC_DEF_BAUD;
            evt_s_reg  <= ASC_DEF_EVT;
            inh_s_reg  <= ASC_DEF_INH;
            hb_s_reg   <= ASC_DEF_HB;
            opt_s_reg  <= ASC_DEF_OPT;
            prog_reg   <= 16'h0000;
        end else if (wr_def) begin
            filt_reg   <= ASC_DEF_FILT;
            baud_s_reg <= ASC_DEF_BAUD;
            evt_s_reg  <= ASC_DEF_EVT;
            inh_s_reg  <= ASC_DEF_INH;
            hb_s_reg   <= ASC_DEF_HB;
            opt_s_reg  <= ASC_DEF_OPT;
        end else if (i_write) begin
            case (i_addr)
                ASC_A_FILT: filt_reg <= i_wdata[7:0];
                ASC_A_BAUD: if (baud_ok) baud_s_reg <= i_wdata[2:0];
                ASC_A_EVT:  if (evt_ok) evt_s_reg <= i_wdata;
                ASC_A_INH:  if (inh_ok_w) inh_s_reg <= i_wdata;
                ASC_A_HB:   if (hb_ok) hb_s_reg <= i_wdata;
                ASC_A_OPT:  opt_s_reg <= i_wdata[3:0];
                ASC_A_PROG: prog_reg <= i_wdata;
                default:    prog_reg <= prog_reg;
            endcase
        end
    end

    // active settings, taken over on apply or save
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_baud_sel <= ASC_DEF_BAUD;
            evt_reg    <= ASC_DEF_EVT;
            inh_reg    <= ASC_DEF_INH;
            hb_reg     <= ASC_DEF_HB;
            opt_reg    <= ASC_DEF_OPT;
        end else if (apply || save) begin
            o_baud_sel <= baud_s_reg;
            evt_reg    <= evt_s_reg;
            inh_reg    <= inh_s_reg;
            hb_reg     <= hb_s_reg;
            opt_reg    <= opt_s_reg;
        end
    end

    // fast tag mode follows the option at once
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fast_mode <= ASC_DEF_OPT[ASC_OB_FAST];
        end else begin
            o_fast_mode <= opt_s_reg[ASC_OB_FAST];
        end
    end

    // node reset and memory write pulses
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            nrst_reg      <= 1'b0;
            o_nvm_save    <= 1'b0;
            o_nvm_default <= 1'b0;
        end else begin
            nrst_reg      <= apply || save;
            o_nvm_save    <= save;
            o_nvm_default <= wr_def;
        end
    end
    assign o_node_reset = nrst_reg;

    // internal status, sticky, write one to clear, set wins
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            int_reg <= 2'b00;
        end else begin
            int_reg[ASC_IS_BAUD]  <= (i_write && i_addr == ASC_A_BAUD && !baud_ok) ||
                (int_reg[ASC_IS_BAUD] && !(i_write && i_addr == ASC_A_INT && i_wdata[ASC_IS_BAUD]));
            int_reg[ASC_IS_RANGE] <= (i_write && ((i_addr == ASC_A_EVT && !evt_ok) ||
                (i_addr == ASC_A_INH && !inh_ok_w) || (i_addr == ASC_A_HB && !hb_ok))) ||
                (int_reg[ASC_IS_RANGE] && !(i_write && i_addr == ASC_A_INT && i_wdata[ASC_IS_RANGE]));
        end
    end

    // node state machine
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ASC_DEF_OPT[ASC_OB_AUTO] ? ASC_ST_OP : ASC_ST_PRE;
        end else if (nrst_reg) begin
            state_reg <= opt_reg[ASC_OB_AUTO] ? ASC_ST_OP : ASC_ST_PRE;
        end else begin
            case (state_reg)
                ASC_ST_STOP: begin
                    if (i_nmt_start) state_reg <= ASC_ST_OP;
                    else if (i_nmt_preop) state_reg <= ASC_ST_PRE;
                end
                ASC_ST_PRE: begin
                    if (i_nmt_start) state_reg <= ASC_ST_OP;
                    else if (i_nmt_stop) state_reg <= ASC_ST_STOP;
                end
                ASC_ST_OP: begin
                    if (i_nmt_preop) state_reg <= ASC_ST_PRE;
                    else if (i_nmt_stop) state_reg <= ASC_ST_STOP;
                end
                default: state_reg <= ASC_ST_PRE;
            endcase
        end
    end

    // reported node state and link status
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_node_state <= ASC_ST_STOP;
            o_can_online <= 1'b0;
        end else begin
            o_node_state <= state_reg;
            o_can_online <= !(i_bus_off || i_bus_lost);
        end
    end

    // last read tag code
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            last_code_reg <= 16'h0000;
        end else if (i_tag_valid) begin
            last_code_reg <= i_tag_code;
        end
    end

    // pending process data: on entering operational, on period, on new code
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            was_op_reg <= 1'b0;
            pend_reg   <= 1'b0;
        end else begin
            was_op_reg <= state_reg == ASC_ST_OP && !nrst_reg; // node reset with autostart re-enters operational
            if ((state_reg == ASC_ST_OP && !was_op_reg) || (evt_due && !tpdo_fire) || new_code) begin
                pend_reg <= 1'b1;
            end else if (tpdo_fire) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // process data send pulse and code
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tpdo_send <= 1'b0;
            o_tpdo_code <= 16'h0000;
        end else begin
            o_tpdo_send <= tpdo_fire;
            if (tpdo_fire) begin
                o_tpdo_code <= opt_reg[ASC_OB_SWAP] ?
                    {last_code_reg[7:0], last_code_reg[15:8]} : last_code_reg;
            end
        end
    end

    // heartbeat pulse
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_heartbeat_send <= 1'b0;
        end else begin
            o_heartbeat_send <= hb_fire;
        end
    end

    // position pulse after the filter gap
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            armed_reg        <= 1'b0;
            o_position_pulse <= 1'b0;
        end else begin
            o_position_pulse <= posi_fire;
            if (i_data_present) armed_reg <= 1'b1;
            else if (posi_fire) armed_reg <= 1'b0;
        end
    end

    // tag programming request
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prog_start <= 1'b0;
            o_prog_code  <= 16'h0000;
        end else begin
            o_prog_start <= prog_fire;
            if (sw_prog) o_prog_code <= prog_reg;
            else if (prog_fire) o_prog_code <= i_req_code;
        end
    end

    // register read, data valid the cycle after the strobe only
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else if (i_read) begin
            case (i_addr)
                ASC_A_FILT: o_rdata <= {8'h00, filt_reg};
                ASC_A_BAUD: o_rdata <= {13'h0000, baud_s_reg};
                ASC_A_EVT:  o_rdata <= evt_s_reg;
                ASC_A_INH:  o_rdata <= inh_s_reg;
                ASC_A_HB:   o_rdata <= hb_s_reg;
                ASC_A_OPT:  o_rdata <= {12'h000, opt_s_reg};
                ASC_A_PROG: o_rdata <= prog_reg;
                ASC_A_STAT: o_rdata <= {13'h0000, state_reg, o_can_online};
                ASC_A_INT:  o_rdata <= {14'h0000, int_reg};
                ASC_A_CODE: o_rdata <= last_code_reg;
                default:    o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // checks
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    AST_POSI_GAP: assert property (o_position_pulse |-> $past(posi_cnt) >= {8'h00, filt_reg})
        else $error("position pulse before filter gap");
    AST_BAUD_SET: assert property (o_baud_sel <= ASC_BAUD_MAX)
        else $error("bit rate index out of set");
    AST_INHIBIT: assert property (o_tpdo_send |-> $past(since_cnt) >= $past(inh_reg))
        else $error("process data inside inhibit time");
    AST_BOTH_ZERO: assert property (both_zero && $past(both_zero) |-> !o_tpdo_send)
        else $error("process data sent with both times zero");
    AST_HB_OFF: assert property (hb_reg == 16'h0000 && $past(hb_reg) == 16'h0000 |-> !o_heartbeat_send)
        else $error("heartbeat sent while disabled");
    AST_PRE_QUIET: assert property (state_reg != ASC_ST_OP |=> !o_tpdo_send)
        else $error("process data outside operational");
    AST_AUTOSTART: assert property (nrst_reg && opt_reg[ASC_OB_AUTO] |=> state_reg == ASC_ST_OP)
        else $error("autostart did not reach operational");
    AST_SWAP: assert property (o_tpdo_send && opt_reg[ASC_OB_SWAP] && $stable(last_code_reg)
        |-> o_tpdo_code == {last_code_reg[7:0], last_code_reg[15:8]})
        else $error("code bytes not swapped");
    AST_SDO_BLOCK: assert property (i_sdo_prog_req && opt_reg[ASC_OB_SDOD] && !i_rpdo_prog_req && !sw_prog
        |=> !o_prog_start)
        else $error("blocked programming request taken");
    AST_APPLY_RST: assert property (apply |=> o_node_reset ##1 !o_node_reset)
        else $error("apply without node reset");
    AST_SAVE: assert property (save |=> o_nvm_save && o_node_reset)
        else $error("save without memory write and reset");
    AST_OFFLINE: assert property (i_bus_off || i_bus_lost |=> !o_can_online)
        else $error("online reported while bus off");

    COV_TPDO: cover property (o_tpdo_send ##[1:1000] o_tpdo_send);
    COV_POSI: cover property ($fell(i_data_present) ##[1:1000] o_position_pulse);
    COV_APPLY: cover property (apply ##1 o_node_reset ##1 state_reg == ASC_ST_PRE);
endmodule

// ### verification/asc_master_model.sv
// Purpose: CAN master stand-in driving node commands and bus health
// Assumes: commands are one-cycle pulses set just after a rising edge
// Notes:   bus health is a level, healthy until told otherwise
`timescale 1ns/1ns
module asc_master_model (
    // clock
    input  wire logic i_clock,
    // node commands and bus health
    output logic      o_nmt_start,
    output logic      o_nmt_preop,
    output logic      o_nmt_stop,
    output logic      o_bus_off,
    output logic      o_bus_lost
);
    // idle: no command, bus healthy
    initial begin
        {o_nmt_start, o_nmt_preop, o_nmt_stop, o_bus_off, o_bus_lost} = 5'h0;
    end
    // node command k: 0 start, 1 pre-operational, 2 stop
    task automatic nmt(input int k);
        @(posedge i_clock);
        o_nmt_start <= (k == 0);
        o_nmt_preop <= (k == 1);
        o_nmt_stop  <= (k == 2);
        @(posedge i_clock);
        {o_nmt_start, o_nmt_preop, o_nmt_stop} <= 3'h0;
    endtask
    // controller bus-off and lost-connection levels
    task automatic bus(input logic off, input logic lost);
        @(posedge i_clock);
        o_bus_off  <= off;
        o_bus_lost <= lost;
    endtask
endmodule

// ### verification/asc_top_tb.sv
// Purpose: self-checking bench of the service and CAN node block
// Assumes: ms tick shortened to 10 cycles
// Notes:   pv bits: 0 pulse 1 pdo 2 beat 3 reset 4 save 5 default 6 prog
`timescale 1ns/1ns
module asc_top_tb import asc_pkg::*; ;
    // dut side signals
    logic        i_clock, i_resetn, i_write, i_read, i_data_present, i_tag_valid;
    logic        i_sdo_prog_req, i_rpdo_prog_req, nmt_go, nmt_pre, nmt_halt, bus_off, bus_lost;
    logic        o_can_online, o_fast_mode;
    logic [1:0]  o_node_state;
    logic [2:0]  o_baud_sel;
    logic [3:0]  i_addr;
    logic [6:0]  pv;
    logic [15:0] i_wdata, i_tag_code, i_req_code, o_rdata, o_tpdo_code, o_prog_code;
    int          fail_count = 0;
    int          n_checks = 0;
    int          n;
    // block under test
    asc_top #(.MS_CYC(10)) dut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_data_present(i_data_present),
        .i_tag_valid(i_tag_valid), .i_tag_code(i_tag_code), .i_bus_off(bus_off), .i_bus_lost(bus_lost),
        .i_nmt_start(nmt_go), .i_nmt_preop(nmt_pre), .i_nmt_stop(nmt_halt),
        .i_sdo_prog_req(i_sdo_prog_req), .i_rpdo_prog_req(i_rpdo_prog_req), .i_req_code(i_req_code),
        .o_position_pulse(pv[0]), .o_tpdo_send(pv[1]), .o_tpdo_code(o_tpdo_code),
        .o_heartbeat_send(pv[2]), .o_node_reset(pv[3]), .o_nvm_save(pv[4]), .o_nvm_default(pv[5]),
        .o_prog_start(pv[6]), .o_prog_code(o_prog_code), .o_node_state(o_node_state),
        .o_can_online(o_can_online), .o_baud_sel(o_baud_sel), .o_fast_mode(o_fast_mode));
    // far side of the CAN link
    asc_master_model m (
        .i_clock(i_clock), .o_nmt_start(nmt_go), .o_nmt_preop(nmt_pre), .o_nmt_stop(nmt_halt),
        .o_bus_off(bus_off), .o_bus_lost(bus_lost));
    // 250 MHz clock
    initial begin
        i_clock = 1'h0;
        forever #2 i_clock = ~i_clock;
    end
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // k edges, then settle past the edge
    task automatic tick(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_write <= 1'h1;
        @(posedge i_clock);
        i_write <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'h1;
        @(posedge i_clock);
        i_read <= 1'h0;
        #1;
        chk(o_rdata, e);
    endtask
    // bounded watch for pulse b, at most lim cycles, looked at mid-cycle so a pulse
    // launched at the calling edge is still seen
    task automatic waitp(input int b, input int lim);
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
        end while (n < lim && pv[b] !== 1'h1);
    endtask
    task automatic need(input int b, input int lim);
        waitp(b, lim);
        if (pv[b] !== 1'h1) begin
            chk(16'h0, 16'h1);
            final_report();
        end
    endtask
    task automatic none(input int b, input int lim);
        waitp(b, lim);
        chk(pv[b], 1'h0);
    endtask
    task automatic tag(input logic [15:0] c);
        @(posedge i_clock);
        i_tag_code  <= c;
        i_tag_valid <= 1'h1;
        @(posedge i_clock);
        i_tag_valid <= 1'h0;
    endtask
    task automatic req(input logic s, input logic [15:0] c);
        @(posedge i_clock);
        i_req_code      <= c;
        i_sdo_prog_req  <= s;
        i_rpdo_prog_req <= !s;
        @(posedge i_clock);
        i_sdo_prog_req  <= 1'h0;
        i_rpdo_prog_req <= 1'h0;
    endtask
    task automatic t_boot();
        chk(o_node_state, ASC_ST_OP);
        chk(o_can_online, 1'h1);
        rd(ASC_A_INT, 16'h0000);
        need(1, 60);
    endtask
    task automatic t_refuse();
        wr(ASC_A_BAUD, 16'h0007);
        rd(ASC_A_BAUD, 16'h0002);
        rd(ASC_A_INT, 16'h0001);
        wr(ASC_A_INT, 16'h0003);
        wr(ASC_A_EVT, 16'h0009);
        rd(ASC_A_INT, 16'h0002);
        wr(ASC_A_INT, 16'h0003);
        wr(ASC_A_OPT, 16'h0009);
        tick(2);
        chk(o_fast_mode, 1'h1);
        for (int k = 0; k < 7; k++) begin
            wr(ASC_A_BAUD, 16'(k));
            wr(ASC_A_CMD, 16'h0001);
            tick(3);
            chk(o_baud_sel, 16'(k));
        end
    endtask
    task automatic t_swap();
        need(1, 60);
        wr(ASC_A_OPT, 16'h0003);
        wr(ASC_A_CMD, 16'h0001);
        tag(16'h1234);
        need(1, 60);
        chk(o_tpdo_code, 16'h3412);
        wr(ASC_A_OPT, 16'h0001);
        wr(ASC_A_CMD, 16'h0001);
        tag(16'hab01);
        need(1, 60);
        chk(o_tpdo_code, 16'hab01);
    endtask
    task automatic t_event();
        wr(ASC_A_EVT, 16'h000a);
        wr(ASC_A_CMD, 16'h0001);
        need(3, 4);
        need(1, 60);
        need(1, 130);
        chk(n inside {[85:112]}, 1'h1);
        wr(ASC_A_INH, 16'h0014);
        wr(ASC_A_CMD, 16'h0001);
        need(1, 230);
        need(1, 260);
        chk(n > 185, 1'h1);
        wr(ASC_A_EVT, 16'h0000);
        wr(ASC_A_INH, 16'h0000);
        wr(ASC_A_CMD, 16'h0001);
        tag(16'h5555);
        none(1, 300);
    endtask
    task automatic t_heart();
        wr(ASC_A_EVT, 16'h000a);
        wr(ASC_A_INH, 16'h0003);
        wr(ASC_A_HB, 16'h000a);
        wr(ASC_A_OPT, 16'h0000);
        wr(ASC_A_CMD, 16'h0001);
        tick(3);
        chk(o_node_state, ASC_ST_PRE);
        need(2, 120);
        need(2, 120);
        chk(n inside {[90:111]}, 1'h1);
        none(1, 250);
        wr(ASC_A_HB, 16'h0000);
        wr(ASC_A_CMD, 16'h0001);
        none(2, 300);
    endtask
    task automatic t_prog();
        wr(ASC_A_OPT, 16'h0004);
        wr(ASC_A_CMD, 16'h0001);
        req(1'h1, 16'h0102);
        none(6, 5);
        req(1'h0, 16'hffff);
        need(6, 4);
        chk(o_prog_code, 16'hffff);
        wr(ASC_A_PROG, 16'h8000);
        wr(ASC_A_CMD, 16'h0008);
        need(6, 4);
        chk(o_prog_code, 16'h8000);
        wr(ASC_A_OPT, 16'h0000);
        wr(ASC_A_CMD, 16'h0001);
        req(1'h1, 16'h0102);
        need(6, 4);
        chk(o_prog_code, 16'h0102);
    endtask
    task automatic t_save();
        wr(ASC_A_HB, 16'h0014);
        wr(ASC_A_CMD, 16'h0002);
        need(4, 3);
        chk(pv[3], 1'h1);
        wr(ASC_A_CMD, 16'h0004);
        need(5, 3);
        rd(ASC_A_HB, ASC_DEF_HB);
    endtask
    task automatic t_filter();
        for (int f = 2; f >= 0; f -= 2) begin
            wr(ASC_A_FILT, 16'(f));
            wr(ASC_A_CMD, 16'h0001);
            @(posedge i_clock);
            i_data_present <= 1'h1;
            none(0, 30);
            @(posedge i_clock);
            i_data_present <= 1'h0;
            if (f != 0)
                none(0, 9);
            need(0, (f != 0) ? 40 : 3);
        end
    endtask
    task automatic t_bus();
        m.bus(1'h1, 1'h0);
        tick(2);
        chk(o_can_online, 1'h0);
        m.bus(1'h0, 1'h1);
        tick(2);
        chk(o_can_online, 1'h0);
        m.bus(1'h0, 1'h0);
        tick(2);
        chk(o_can_online, 1'h1);
        for (int k = 0; k < 3; k++) begin
            m.nmt(k);
            tick(2);
            chk(o_node_state, (k == 0) ? ASC_ST_OP : (k == 1) ? ASC_ST_PRE : ASC_ST_STOP);
        end
    endtask
    // reset, then the scenarios in turn
    initial begin
        {i_resetn, i_write, i_read, i_data_present, i_tag_valid} = 5'h0;
        {i_sdo_prog_req, i_rpdo_prog_req, i_addr} = 6'h0;
        {i_wdata, i_tag_code, i_req_code} = 48'h0;
        repeat (4) @(posedge i_clock);
        i_resetn <= 1'h1;
        tick(1);
        t_boot();
        t_refuse();
        t_swap();
        t_event();
        t_heart();
        t_prog();
        t_save();
        t_filter();
        t_bus();
        final_report();
    end
endmodule
